// File: rtl/acsc_top.v
// Converter digital control: direct pins, serial configuration port and serial output lanes
//
// Operation
// - Power-down pin holds its channel down
// - Lock flag high while loop locked
// - Lane config one selects single lane
// - Test pin sends fixed pattern
// - Alignment pin offsets or aligns dual lanes
// - Serial enable overrides direct control pins
// - Twelve-bit word, bit zero zero for conversion data
// - Both output clock edges carry data
// - Overrange flag updated once per frame
// - Access is sixteen clocks per select
// - Sample rising, change falling serial edges
// - Short access is discarded entirely
// - Select rise latches address, writes data
// - Flag one reads, zero writes
// - Two-bit address, read ignores data
// - Output driven only while selected
// - Address pointer resets to zero
// - User pattern from two registers
// - Format pin picks coding and stabilizer
`timescale 1ns/1ps
`default_nettype none
`include "acsc_map.vh"
module acsc_top (
  input wire mclk,
  input wire srst,
  input wire powerdown_chan_a,
  input wire powerdown_chan_b,
  input wire dll_reset,
  input wire lane_config,
  input wire word_align_select,
  input wire test_enable,
  input wire serial_port_enable,
  input wire [1:0] format_stabilizer_select,
  input wire serial_clk,
  input wire serial_select_n,
  input wire serial_data_in,
  input wire [10:0] sample_chan_a,
  input wire [10:0] sample_chan_b,
  input wire range_fault_a,
  input wire range_fault_b,
  output reg serial_data_out,
  output reg serial_data_oe,
  output reg chan_a_down,
  output reg chan_b_down,
  output reg dll_lock,
  output wire lane_zero_data_a,
  output wire lane_one_data_a,
  output wire lane_zero_data_b,
  output wire lane_one_data_b,
  output reg output_bit_clock,
  output reg frame_marker,
  output reg overrange_chan_a,
  output reg overrange_chan_b,
  output reg twos_complement,
  output reg stabilizer_enable,
  output reg [1:0] serial_addr_ptr
);
  localparam integer RELOCK_INT = `ACSC_DLL_RELOCK_CYC;
  localparam [9:0] RELOCK_CYC = RELOCK_INT[9:0];

  wire [9:0] pin_sync;
  wire [2:0] spi_sync;
  reg sclk_d_r;
  reg csn_d_r;
  wire sclk_s;
  wire csn_s;
  wire sdi_s;
  wire sclk_rise;
  wire sclk_fall;
  wire csn_rise;
  wire csn_fall;

  // Every pin from outside the clock domain passes two flops
  acsc_sync #(.WIDTH(10), .RST_VAL(10'h000)) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .din({format_stabilizer_select, serial_port_enable, test_enable, word_align_select,
          lane_config, dll_reset, powerdown_chan_b, powerdown_chan_a, 1'b0}),
    .dout(pin_sync)
  );

  acsc_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_spi_sync (
    .mclk(mclk),
    .srst(srst),
    .din({serial_clk, serial_select_n, serial_data_in}),
    .dout(spi_sync)
  );

  assign sclk_s = spi_sync[2];
  assign csn_s = spi_sync[1];
  assign sdi_s = spi_sync[0];
  assign sclk_rise = sclk_s & ~sclk_d_r & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~csn_s;
  assign csn_rise = csn_s & ~csn_d_r;
  assign csn_fall = ~csn_s & csn_d_r;

  // Serial port state
  reg [4:0] bit_cnt_r;
  reg [7:0] shift_in_r;
  reg [7:0] shift_out_r;
  reg [7:0] cmd_r;
  reg [7:0] control_r;
  reg [7:0] pat_high_r;
  reg [7:0] pat_low_r;

  function [7:0] reg_read;
    input [1:0] addr;
    input [7:0] ctl;
    input [7:0] phi;
    input [7:0] plo;
    begin
      case (addr)
        `ACSC_ADDR_CONTROL: reg_read = ctl & `ACSC_CONTROL_MASK;
        `ACSC_ADDR_PAT_HIGH: reg_read = phi & `ACSC_PAT_HIGH_MASK;
        `ACSC_ADDR_PAT_LOW: reg_read = plo & `ACSC_PAT_LOW_MASK;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] cmd_now;
  wire [1:0] cmd_addr;
  wire cmd_read;
  assign cmd_now = {shift_in_r[6:0], sdi_s};
  assign cmd_addr = cmd_r[`ACSC_CMD_ADDR_MSB:`ACSC_CMD_ADDR_LSB];
  assign cmd_read = cmd_r[`ACSC_CMD_RW_BIT];

  // A select rise after fewer than sixteen clocks leaves every register alone
  wire commit;
  assign commit = csn_rise && (bit_cnt_r == `ACSC_SPI_BITS);

  always @(posedge mclk) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
      csn_d_r <= 1'b1;
      bit_cnt_r <= 5'h00;
      shift_in_r <= 8'h00;
      shift_out_r <= 8'h00;
      cmd_r <= 8'h00;
      serial_addr_ptr <= `ACSC_ADDR_RESET;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      csn_d_r <= csn_s;
      serial_data_oe <= ~csn_s;
      if (csn_fall) begin
        bit_cnt_r <= 5'h00;
        serial_data_out <= 1'b0;
      end
      if (sclk_rise && bit_cnt_r != `ACSC_SPI_BITS) begin
        shift_in_r <= cmd_now;
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == `ACSC_SPI_HALF - 5'h01) begin
          cmd_r <= cmd_now;
          shift_out_r <= reg_read(cmd_now[`ACSC_CMD_ADDR_MSB:`ACSC_CMD_ADDR_LSB],
                                  control_r, pat_high_r, pat_low_r);
        end
      end
      // Read data leaves on the falling edges of clocks eight to fifteen
      if (sclk_fall && bit_cnt_r >= `ACSC_SPI_HALF && bit_cnt_r != `ACSC_SPI_BITS) begin
        serial_data_out <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
      // Only a full sixteen-clock access commits anything
      if (commit) begin
        serial_addr_ptr <= cmd_addr;
      end
      if (csn_rise) begin
        serial_data_out <= 1'b0;
      end
    end
  end

  // Write decode; address 3 matches nothing, so writes there vanish
  function reg_hit;
    input [1:0] addr;
    input [1:0] sel;
    input rd;
    begin
      reg_hit = (addr == sel) && !rd;
    end
  endfunction

  always @(posedge mclk) begin
    if (srst) begin
      control_r <= `ACSC_CONTROL_RESET;
    end else if (commit && reg_hit(cmd_addr, `ACSC_ADDR_CONTROL, cmd_read)) begin
      control_r <= shift_in_r & `ACSC_CONTROL_MASK;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      pat_high_r <= `ACSC_PAT_HIGH_RESET;
    end else if (commit && reg_hit(cmd_addr, `ACSC_ADDR_PAT_HIGH, cmd_read)) begin
      pat_high_r <= shift_in_r & `ACSC_PAT_HIGH_MASK;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      pat_low_r <= `ACSC_PAT_LOW_RESET;
    end else if (commit && reg_hit(cmd_addr, `ACSC_ADDR_PAT_LOW, cmd_read)) begin
      pat_low_r <= shift_in_r & `ACSC_PAT_LOW_MASK;
    end
  end

  // Effective controls: serial registers or direct pins
  wire spi_on;
  reg pd_a_eff;
  reg pd_b_eff;
  reg single_eff;
  reg align_eff;
  reg test_eff;
  reg twos_eff;
  reg dcs_eff;
  assign spi_on = pin_sync[7];

  always @* begin
    if (spi_on) begin
      pd_a_eff = control_r[`ACSC_CTL_PD_A];
      pd_b_eff = control_r[`ACSC_CTL_PD_B];
      single_eff = control_r[`ACSC_CTL_LANE];
      align_eff = control_r[`ACSC_CTL_ALIGN];
      test_eff = control_r[`ACSC_CTL_TEST];
      twos_eff = control_r[`ACSC_CTL_TWOS];
      dcs_eff = control_r[`ACSC_CTL_DCS];
    end else begin
      pd_a_eff = pin_sync[1];
      pd_b_eff = pin_sync[2];
      single_eff = pin_sync[4];
      align_eff = pin_sync[5];
      test_eff = pin_sync[6];
      twos_eff = pin_sync[9];
      dcs_eff = pin_sync[9] ^ pin_sync[8];
    end
  end

  // Loop lock model: a reset pulse drops lock, relock after a fixed wait
  reg [9:0] lock_cnt_r;
  always @(posedge mclk) begin
    if (srst || pin_sync[3]) begin
      lock_cnt_r <= 10'h000;
      dll_lock <= 1'b0;
    end else if (lock_cnt_r != RELOCK_CYC) begin
      lock_cnt_r <= lock_cnt_r + 10'h001;
      dll_lock <= 1'b0;
    end else begin
      dll_lock <= 1'b1;
    end
  end

  // Frame timing: twelve cycles a word in both lane modes
  reg [3:0] frame_cnt_r;
  wire frame_load;
  assign frame_load = (frame_cnt_r == `ACSC_FRAME_LAST);

  always @(posedge mclk) begin
    if (srst) begin
      frame_cnt_r <= 4'h0;
      output_bit_clock <= 1'b0;
      frame_marker <= 1'b0;
      overrange_chan_a <= 1'b0;
      overrange_chan_b <= 1'b0;
      chan_a_down <= 1'b0;
      chan_b_down <= 1'b0;
      twos_complement <= 1'b0;
      stabilizer_enable <= 1'b0;
    end else begin
      frame_cnt_r <= frame_load ? 4'h0 : frame_cnt_r + 4'h1;
      // Each bit spans half a clock period; dual lane halves the rate
      output_bit_clock <= single_eff ? ~frame_cnt_r[0] : ~frame_cnt_r[1];
      frame_marker <= (frame_cnt_r < 4'h6);
      if (frame_load) begin
        overrange_chan_a <= range_fault_a & ~pd_a_eff;
        overrange_chan_b <= range_fault_b & ~pd_b_eff;
      end
      chan_a_down <= pd_a_eff;
      chan_b_down <= pd_b_eff;
      twos_complement <= twos_eff;
      stabilizer_enable <= dcs_eff;
    end
  end

  // Word assembly: conversion data, fixed pattern or user pattern
  wire [11:0] user_pattern;
  wire [21:0] samples;
  wire [1:0] pd_vec;
  wire [1:0] lane_zero_vec;
  wire [1:0] lane_one_vec;
  assign user_pattern = {pat_high_r[5:0], pat_low_r[7:2]};
  assign samples = {sample_chan_b, sample_chan_a};
  assign pd_vec = {pd_b_eff, pd_a_eff};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg [11:0] word;
      wire [10:0] raw;
      assign raw = samples[ch*11 +: 11];
      always @* begin
        word = {raw[10] ^ twos_eff, raw[9:0], 1'b0};
        if (test_eff) begin
          // Pin test mode has no pattern register; serial mode uses the user pattern
          word = spi_on ? user_pattern : `ACSC_FIXED_PATTERN;
        end
        if (pd_vec[ch]) begin
          word = 12'h000;
        end
      end
      acsc_lane_ser u_ser (
        .mclk(mclk),
        .srst(srst),
        .load(frame_load),
        .word(word),
        .bit_cnt(frame_cnt_r),
        .dual(~single_eff),
        .aligned(align_eff),
        .lane_zero_r(lane_zero_vec[ch]),
        .lane_one_r(lane_one_vec[ch])
      );
    end
  endgenerate

  assign lane_zero_data_a = lane_zero_vec[0];
  assign lane_one_data_a = lane_one_vec[0];
  assign lane_zero_data_b = lane_zero_vec[1];
  assign lane_one_data_b = lane_one_vec[1];
endmodule // acsc_top
`default_nettype wire

// File: rtl/acsc_map.vh
// Constants for the converter control and serial configuration block
`ifndef ACSC_MAP_VH
`define ACSC_MAP_VH

`define ACSC_CLK_PERIOD_NS 10
`define ACSC_DLL_PULSE_NS 1000
`define ACSC_DLL_RELOCK_NS 5000
`define ACSC_DLL_RELOCK_CYC ((`ACSC_DLL_RELOCK_NS) / (`ACSC_CLK_PERIOD_NS))

`define ACSC_WORD_BITS 12
`define ACSC_FRAME_LAST 4'hB
`define ACSC_FIXED_PATTERN 12'hA63

`define ACSC_SPI_BITS 5'h10
`define ACSC_SPI_HALF 5'h08
`define ACSC_CMD_RW_BIT 7
`define ACSC_CMD_ADDR_MSB 1
`define ACSC_CMD_ADDR_LSB 0

`define ACSC_ADDR_CONTROL 2'h0
`define ACSC_ADDR_PAT_HIGH 2'h1
`define ACSC_ADDR_PAT_LOW 2'h2
`define ACSC_ADDR_RESET 2'h0

`define ACSC_CONTROL_RESET 8'h00
`define ACSC_CONTROL_MASK 8'h7F
`define ACSC_PAT_HIGH_RESET 8'h00
`define ACSC_PAT_HIGH_MASK 8'h3F
`define ACSC_PAT_LOW_RESET 8'h00
`define ACSC_PAT_LOW_MASK 8'hFC

`define ACSC_CTL_PD_A 0
`define ACSC_CTL_PD_B 1
`define ACSC_CTL_LANE 2
`define ACSC_CTL_ALIGN 3
`define ACSC_CTL_TEST 4
`define ACSC_CTL_TWOS 5
`define ACSC_CTL_DCS 6

`endif

// File: rtl/acsc_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module acsc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire srst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge mclk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // acsc_sync
`default_nettype wire

// File: rtl/acsc_lane_ser.v
// One channel's word serialiser for single or dual lane output
`timescale 1ns/1ps
`default_nettype none
`include "acsc_map.vh"
module acsc_lane_ser (
  input wire mclk,
  input wire srst,
  input wire load,
  input wire [11:0] word,
  input wire [3:0] bit_cnt,
  input wire dual,
  input wire aligned,
  output reg lane_zero_r,
  output reg lane_one_r
);
  reg [11:0] cur_r;
  reg [11:0] prev_r;
  reg [3:0] idx1;
  reg [3:0] idx0;
  reg use_prev;
  reg lane_zero_nxt;
  reg lane_one_nxt;
  wire [2:0] half_k;

  assign half_k = bit_cnt[3:1];

  always @* begin
    idx1 = 4'hB - bit_cnt;
    idx0 = 4'h0;
    use_prev = 1'b0;
    lane_zero_nxt = 1'b0;
    lane_one_nxt = cur_r[idx1];
    if (dual) begin
      idx1 = 4'hB - {1'b0, half_k};
      if (aligned) begin
        idx0 = 4'h5 - {1'b0, half_k};
      end else if (half_k >= 3'h3) begin
        idx0 = 4'h8 - {1'b0, half_k};
      end else begin
        idx0 = 4'h2 - {1'b0, half_k};
        use_prev = 1'b1;
      end
      lane_one_nxt = cur_r[idx1];
      lane_zero_nxt = use_prev ? prev_r[idx0] : cur_r[idx0];
    end
  end

  // The half-word offset borrows the tail of the previous word
  always @(posedge mclk) begin
    if (srst) begin
      cur_r <= 12'h000;
      prev_r <= 12'h000;
      lane_zero_r <= 1'b0;
      lane_one_r <= 1'b0;
    end else begin
      if (load) begin
        cur_r <= word;
        prev_r <= cur_r;
      end
      lane_zero_r <= lane_zero_nxt;
      lane_one_r <= lane_one_nxt;
    end
  end
endmodule // acsc_lane_ser
`default_nettype wire

// File: verification/acsc_chk.sv
// Assertion checker for the control and serial configuration block
`timescale 1ns/1ps
`default_nettype none
module acsc_chk (
  input wire mclk,
  input wire srst,
  input wire powerdown_chan_a,
  input wire dll_reset,
  input wire serial_port_enable,
  input wire [1:0] format_stabilizer_select,
  input wire serial_clk,
  input wire serial_select_n,
  input wire serial_data_out,
  input wire serial_data_oe,
  input wire chan_a_down,
  input wire dll_lock,
  input wire frame_marker,
  input wire overrange_chan_a,
  input wire twos_complement,
  input wire stabilizer_enable,
  input wire [1:0] serial_addr_ptr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Margins cover the two-flop synchronisers on every pin
  oe_idle_a: assert property (serial_select_n[*5] |-> !serial_data_oe)
    else $error("sdo driven while idle");
  oe_drive_a: assert property (!serial_select_n[*5] |-> serial_data_oe)
    else $error("sdo not driven while selected");
  pd_pin_a: assert property ((!serial_port_enable && powerdown_chan_a)[*6] |-> chan_a_down)
    else $error("pin power-down not applied");
  fmt_pin_a: assert property ((!serial_port_enable && $stable(format_stabilizer_select))[*6] |->
    twos_complement == format_stabilizer_select[1] && stabilizer_enable == ^format_stabilizer_select)
    else $error("format pin decode wrong");
  lock_drop_a: assert property (dll_reset[*6] |-> !dll_lock)
    else $error("lock held during loop reset");
  lock_back_a: assert property ($fell(dll_reset) |-> ##[1:700] dll_lock)
    else $error("loop did not relock");
  frame_shape_a: assert property ($rose(frame_marker) |-> frame_marker[*6] ##1 !frame_marker[*6] ##1 frame_marker)
    else $error("frame marker shape wrong");
  ovr_frame_a: assert property ($changed(overrange_chan_a) |=> $stable(overrange_chan_a)[*8])
    else $error("overrange changed within a frame");
  ptr_upd_a: assert property ($changed(serial_addr_ptr) |-> serial_select_n && $past(serial_select_n))
    else $error("pointer moved while selected");
  sdo_hold_a: assert property (serial_clk[*4] |-> $stable(serial_data_out))
    else $error("sdo changed while clock high");
  cover property (!serial_select_n ##1 serial_select_n);
  cover property ($rose(dll_lock));
  cover property ($rose(overrange_chan_a));
endmodule // acsc_chk
`default_nettype wire

// File: verification/acsc_host.sv
// Host model driving the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module acsc_host (
  output var logic serial_clk,
  output var logic serial_select_n,
  output var logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  initial begin
    serial_clk = 1'h0; // Parked low between accesses
    serial_select_n = 1'h1;
    serial_data_in = 1'h0;
  end
  // Sends n clocks of a frame, command byte first, MSB first
  task automatic xfer(input logic [15:0] frm, input int n, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    serial_select_n = 1'h0;
    for (i = 0; i < n; i++) begin
      serial_data_in = frm[15 - i];
      #62.5 serial_clk = 1'h1; // Device samples on the rise
      if (i > 7) rd = {rd[6:0], serial_data_oe === 1'h1 ? serial_data_out : ~rd[0]};
      #62.5 serial_clk = 1'h0;
    end
    serial_data_in = ~serial_data_in; // Released line shows no stale value
    #62.5 serial_select_n = 1'h1; // Released after the last clock
    #62.5;
  endtask
endmodule // acsc_host
`default_nettype wire

// File: verification/tb_acsc_top.sv
// Testbench for the control and serial configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_acsc_top;
  logic mclk = 1'h0, srst = 1'h1, powerdown_chan_a = 1'h0, powerdown_chan_b = 1'h0, dll_reset = 1'h0;
  logic lane_config = 1'h1, word_align_select = 1'h0, test_enable = 1'h0, serial_port_enable = 1'h1;
  logic range_fault_a = 1'h0, range_fault_b = 1'h0;
  logic [1:0] format_stabilizer_select = 2'h0;
  logic [10:0] sample_chan_a = 11'h7FF, sample_chan_b = 11'h2AA;
  logic word_ch = 1'h0;
  wire serial_clk, serial_select_n, serial_data_in, serial_data_out, serial_data_oe, chan_a_down, chan_b_down;
  wire dll_lock, lane_zero_data_a, lane_one_data_a, lane_zero_data_b, lane_one_data_b, output_bit_clock;
  wire frame_marker, overrange_chan_a, overrange_chan_b, twos_complement, stabilizer_enable;
  wire [1:0] serial_addr_ptr;
  int n_fail = 0, checks = 0, a;
  logic [11:0] d, w;
  acsc_top dut (.*);
  acsc_host host (.*);
  always #5 mclk = ~mclk; // Sample clock never stops, the port needs it
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] ad, input logic [7:0] dt);
    logic [7:0] r;
    host.xfer({6'h00, ad, dt}, 16, r); // Flag zero writes
  endtask
  task automatic rd(input logic [1:0] ad, output logic [11:0] dt);
    logic [7:0] r;
    host.xfer({6'h20, ad, 8'hA5}, 16, r); // Flag one reads, data field ignored
    dt = {4'h0, r};
  endtask
  // Captures the word_ch channel's word from the start of the next frame
  task automatic word(input logic dual, output logic [11:0] wd);
    int i;
    cyc(1);
    for (i = 0; i < 30 && frame_marker !== 1'h0; i++) cyc(1);
    for (i = 0; i < 30 && frame_marker !== 1'h1; i++) cyc(1);
    for (i = 0; i < (dual ? 6 : 12); i++) begin
      wd = dual ? {wd[10:6], word_ch ? lane_one_data_b : lane_one_data_a, wd[4:0],
                   word_ch ? lane_zero_data_b : lane_zero_data_a}
                : {wd[10:0], word_ch ? lane_one_data_b : lane_one_data_a};
      cyc(dual ? 2 : 1);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    $display("Error watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    cyc(6);
    srst = 1'h0;
    for (a = 0; a < 700 && dll_lock !== 1'h1; a++) cyc(1);
    chk("lock", 12'h001, {11'h000, dll_lock});
    dll_reset = 1'h1; // One microsecond pulse
    cyc(100);
    chk("lock in reset", 12'h000, {11'h000, dll_lock});
    dll_reset = 1'h0;
    for (a = 0; a < 700 && dll_lock !== 1'h1; a++) cyc(1);
    chk("relock", 12'h001, {11'h000, dll_lock});
    $display("test loop done");
    chk("pointer", 12'h000, {10'h000, serial_addr_ptr});
    for (a = 0; a < 4; a++) begin
      rd(a[1:0], d);
      chk("reset value", 12'h000, d);
      chk("pointer", a[11:0], {10'h000, serial_addr_ptr});
    end
    for (a = 0; a < 4; a++) begin
      wr(a[1:0], 8'hFF);
      rd(a[1:0], d);
      chk("masked", a == 0 ? 12'h07F : a == 1 ? 12'h03F : a == 2 ? 12'h0FC : 12'h000, d);
    end
    $display("test registers done");
    host.xfer(16'h0100, 15, d[7:0]); // Dropped one clock short
    chk("short pointer", 12'h003, {10'h000, serial_addr_ptr});
    rd(2'h1, d);
    chk("short data", 12'h03F, d);
    $display("test short access done");
    wr(2'h1, 8'h2A);
    wr(2'h2, 8'hCC);
    wr(2'h0, 8'h14);
    cyc(30);
    word(1'h0, w);
    chk("user single", 12'hAB3, w);
    wr(2'h0, 8'h18);
    cyc(30);
    word(1'h1, w);
    chk("user aligned", 12'hAB3, w);
    wr(2'h0, 8'h10);
    cyc(30);
    word(1'h1, w);
    chk("user offset", 12'hA9E, w);
    $display("test user pattern done");
    cyc(1);
    serial_port_enable = 1'h0;
    test_enable = 1'h1;
    word_align_select = 1'h0; // Held low in single lane
    cyc(30);
    word(1'h0, w);
    chk("fixed pattern", 12'hA63, w);
    word_ch = 1'h1;
    word(1'h0, w);
    chk("fixed pattern b", 12'hA63, w);
    test_enable = 1'h0;
    cyc(30);
    word(1'h0, w);
    chk("data word b", 12'h554, w);
    word_ch = 1'h0;
    word(1'h0, w);
    chk("data word", 12'hFFE, w);
    d[0] = output_bit_clock;
    cyc(1);
    chk("bit clock single", 12'h001, {11'h000, d[0] ^ output_bit_clock});
    lane_config = 1'h0;
    word_align_select = 1'h1;
    cyc(30);
    word(1'h1, w);
    chk("dual word", 12'hFFE, w);
    d[0] = output_bit_clock;
    cyc(2);
    chk("bit clock dual", 12'h001, {11'h000, d[0] ^ output_bit_clock});
    word_ch = 1'h1;
    word(1'h1, w);
    chk("dual word b", 12'h554, w);
    word_ch = 1'h0;
    $display("test pins done");
    powerdown_chan_a = 1'h1;
    cyc(10);
    chk("pin down", 12'h001, {11'h000, chan_a_down});
    serial_port_enable = 1'h1;
    cyc(10);
    chk("pin ignored", 12'h000, {11'h000, chan_a_down});
    wr(2'h0, 8'h02);
    cyc(10);
    chk("reg down", 12'h002, {10'h000, chan_b_down, chan_a_down});
    serial_port_enable = 1'h0;
    powerdown_chan_a = 1'h0;
    for (a = 0; a < 4; a++) begin
      format_stabilizer_select = a[1:0];
      cyc(10);
      chk("format", {10'h000, a[1], ^a[1:0]}, {10'h000, twos_complement, stabilizer_enable});
    end
    range_fault_a = 1'h1;
    range_fault_b = 1'h1;
    cyc(30);
    chk("overrange", 12'h003, {10'h000, overrange_chan_b, overrange_chan_a});
    range_fault_a = 1'h0;
    range_fault_b = 1'h0;
    cyc(30);
    chk("in range", 12'h000, {10'h000, overrange_chan_b, overrange_chan_a});
    $display("test control done");
    wrap_up();
  end
endmodule // tb_acsc_top
bind acsc_top acsc_chk chk (.*);
`default_nettype wire
